//--- hw/ftcr_defines.svh
// Command offsets, reset values and timing constants of the feed threshold registers
`ifndef FTCR_DEFINES_SVH
`define FTCR_DEFINES_SVH

// ----------------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------------
`define FTCR_CMD_OUT2_DELAY   8'hE2
`define FTCR_CMD_PROD_CONFIG  8'hE3
`define FTCR_CMD_HOLDUP_TRIG  8'hE4
`define FTCR_CMD_DISABLE_THR  8'hE5
`define FTCR_CMD_ENABLE_THR   8'hE6
`define FTCR_CMD_RAISE_THR    8'hE7
`define FTCR_CMD_CEASE_THR    8'hE8
`define FTCR_CMD_FA_POS_CAL   8'hE9
`define FTCR_CMD_FA_OFS_CAL   8'hEA
`define FTCR_CMD_I1_SLOPE_CAL 8'hEB
`define FTCR_CMD_I1_OFS_CAL   8'hEC
`define FTCR_CMD_FA_NEG_CAL   8'hED
`define FTCR_CMD_FB_POS_CAL   8'hEE
`define FTCR_CMD_FB_OFS_CAL   8'hEF
`define FTCR_CMD_FB_NEG_CAL   8'hF0
`define FTCR_CMD_FW_INFO      8'hFD

// ----------------------------------------------------------------------------
// Word storage layout: index is command minus first word command
// ----------------------------------------------------------------------------
`define FTCR_WORD_FIRST       8'hE2
`define FTCR_WORD_LAST        8'hF0
`define FTCR_WORD_COUNT       15
`define FTCR_WORD_RESET       16'h0000
`define FTCR_READ_UNMAPPED    16'hFFFF
`define FTCR_TX_FILL          8'hFF

// ----------------------------------------------------------------------------
// Direct format of voltage words: m, b, R and step in millivolts
// ----------------------------------------------------------------------------
`define FTCR_DIRECT_M         6400
`define FTCR_DIRECT_B         0
`define FTCR_DIRECT_R         (-2)
`define FTCR_DIRECT_STEP_MV   15.625

// ----------------------------------------------------------------------------
// Serial link constants
// ----------------------------------------------------------------------------
`define FTCR_SLAVE_ADDR       7'h20
`define FTCR_FW_LEN           20
`define FTCR_FW_LEN_BYTE      8'h14
`define FTCR_FW_STRING        "FW 00.00.00 BUILD 01"

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define FTCR_CLK_PERIOD_NS    20
`define FTCR_MS_NS            1000000
`define FTCR_MS_CYCLES        (`FTCR_MS_NS / `FTCR_CLK_PERIOD_NS)

`endif

//--- hw/ftcr_pkg.sv
// Types shared by the feed threshold register block
package ftcr_pkg;

  // Serial engine states
  typedef enum logic [2:0] {
    LINK_IDLE = 3'h0,
    LINK_RX   = 3'h1,
    LINK_ACK  = 3'h2,
    LINK_TX   = 3'h3,
    LINK_MACK = 3'h4
  } ftcr_link_state_t;

  typedef logic [15:0] ftcr_word_t;

endpackage

//--- hw/ftcr_regs.sv
// Feed threshold and calibration command set behind the management bus
`timescale 1ns/1ps
`include "ftcr_defines.svh"

module ftcr_regs #(
  parameter int CYC_PER_MS = `FTCR_MS_CYCLES
) (
  input  wire logic        CORE_CLK,
  input  wire logic        SYS_RST,
  input  wire logic        LINK_CLK,
  input  wire logic        SCL_IN,
  input  wire logic        SDA_IN,
  output logic             SDA_OUT,
  output logic             SDA_OE,
  input  wire logic        EN_A_PLUGGED,
  input  wire logic        EN_B_PLUGGED,
  input  wire logic [15:0] VIN_A,
  input  wire logic [15:0] VIN_B,
  input  wire logic [15:0] VOUT,
  output logic             OUTPUTS_ON,
  output logic             OUT2_START,
  output logic             HOLDUP_ON,
  output logic             FEED_A_EN,
  output logic             FEED_B_EN,
  output logic             FEED_ALARM,
  output logic             OUT_VOLT_OK,
  output logic [15:0]      CAL_FA_POS,
  output logic [15:0]      CAL_FA_NEG,
  output logic [15:0]      CAL_FA_OFS,
  output logic [15:0]      CAL_FB_POS,
  output logic [15:0]      CAL_FB_NEG,
  output logic [15:0]      CAL_FB_OFS,
  output logic [15:0]      CAL_I1_SLOPE,
  output logic [15:0]      CAL_I1_OFS
);

  // --------------------------------------------------------------------------
  // Shared decode
  // --------------------------------------------------------------------------
  function automatic logic is_word_cmd(input logic [7:0] c);
    return (c >= `FTCR_WORD_FIRST) && (c <= `FTCR_WORD_LAST);
  endfunction

  function automatic logic [3:0] word_index(input logic [7:0] c);
    logic [7:0] d;
    d = c - `FTCR_WORD_FIRST;
    return d[3:0];
  endfunction

  localparam logic [159:0] FW_TEXT = `FTCR_FW_STRING;

  // Byte sent at position idx of a read answer
  function automatic logic [7:0] tx_byte(input logic [7:0] c, input logic [4:0] idx,
                                         input logic [15:0] w);
    logic [7:0] b;
    b = `FTCR_TX_FILL;
    if (c == `FTCR_CMD_FW_INFO) begin
      if (idx == 5'h00) begin
        b = `FTCR_FW_LEN_BYTE;
      end else if (int'(idx) <= `FTCR_FW_LEN) begin
        b = FW_TEXT[((`FTCR_FW_LEN - int'(idx)) * 8 + 7) -: 8];
      end
    end else if (idx == 5'h00) begin
      b = w[7:0];
    end else if (idx == 5'h01) begin
      b = w[15:8];
    end
    return b;
  endfunction

  // --------------------------------------------------------------------------
  // Link domain: synchronisers
  // --------------------------------------------------------------------------
  logic [2:0] scl_q;
  logic [2:0] sda_q;
  logic [1:0] lrst_q;
  logic [2:0] ack_q;
  logic       lrst;
  logic       scl_rise;
  logic       scl_fall;
  logic       bus_start;
  logic       bus_stop;

  // Two stages per pin plus one history stage
  always_ff @(posedge LINK_CLK) begin
    scl_q  <= {scl_q[1:0], SCL_IN};
    sda_q  <= {sda_q[1:0], SDA_IN};
    lrst_q <= {lrst_q[0], SYS_RST};
  end

  assign lrst      = lrst_q[1];
  assign scl_rise  = scl_q[1] & ~scl_q[2];
  assign scl_fall  = ~scl_q[1] & scl_q[2];
  assign bus_start = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
  assign bus_stop  = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];

  // --------------------------------------------------------------------------
  // Link domain: serial engine
  // --------------------------------------------------------------------------
  ftcr_pkg::ftcr_link_state_t st;
  logic [3:0]         bitcnt;
  logic [7:0]         shreg;
  logic [2:0]         phase;
  logic [7:0]         cmd;
  logic               rd_mode;
  logic               nack;
  logic [4:0]         txi;
  logic [7:0]         low_byte;
  logic               req_tgl;
  logic               req_wr;
  logic [7:0]         req_cmd;
  ftcr_pkg::ftcr_word_t req_data;
  ftcr_pkg::ftcr_word_t rd_word;
  ftcr_pkg::ftcr_word_t core_rdata;
  logic               byte_ok;
  logic [7:0]         first_tx;
  logic [7:0]         next_tx;
  logic               ack_tgl;

  // Acceptance of a received byte by its place in the transfer
  always_comb begin
    unique case (phase)
      3'h0:    byte_ok = (shreg[7:1] == `FTCR_SLAVE_ADDR);
      3'h1:    byte_ok = is_word_cmd(shreg) || (shreg == `FTCR_CMD_FW_INFO);
      3'h2:    byte_ok = is_word_cmd(cmd);
      3'h3:    byte_ok = is_word_cmd(cmd);
      default: byte_ok = 1'b0;
    endcase
  end

  assign first_tx = tx_byte(cmd, 5'h00, rd_word);
  assign next_tx  = tx_byte(cmd, txi, rd_word);

  // Byte framing, acknowledge and answer shifting
  always_ff @(posedge LINK_CLK) begin
    if (lrst) begin
      st       <= ftcr_pkg::LINK_IDLE;
      bitcnt   <= 4'h0;
      shreg    <= 8'h00;
      phase    <= 3'h0;
      cmd      <= 8'h00;
      rd_mode  <= 1'b0;
      nack     <= 1'b0;
      txi      <= 5'h00;
      low_byte <= 8'h00;
      req_tgl  <= 1'b0;
      req_wr   <= 1'b0;
      req_cmd  <= 8'h00;
      req_data <= 16'h0000;
      SDA_OE   <= 1'b0;
      SDA_OUT  <= 1'b0;
    end else if (bus_stop) begin
      st     <= ftcr_pkg::LINK_IDLE;
      SDA_OE <= 1'b0;
    end else if (bus_start) begin
      st      <= ftcr_pkg::LINK_RX;
      bitcnt  <= 4'h0;
      phase   <= 3'h0;
      rd_mode <= 1'b0;
      SDA_OE  <= 1'b0;
    end else begin
      unique case (st)
        ftcr_pkg::LINK_IDLE: begin
          SDA_OE <= 1'b0;
        end
        ftcr_pkg::LINK_RX: begin
          if (scl_rise) begin
            shreg  <= {shreg[6:0], sda_q[1]};
            bitcnt <= bitcnt + 4'h1;
          end else if (scl_fall && bitcnt == 4'h8) begin
            bitcnt <= 4'h0;
            if (phase != 3'h4) begin
              phase <= phase + 3'h1;
            end
            if (phase == 3'h0) begin
              rd_mode <= shreg[0];
            end
            if (phase == 3'h1) begin
              cmd <= shreg;
              if (is_word_cmd(shreg)) begin
                req_wr  <= 1'b0;  // Prefetch for a later word read
                req_cmd <= shreg;
                req_tgl <= ~req_tgl;
              end
            end
            if (phase == 3'h2) begin
              low_byte <= shreg;  // Low byte first
            end
            if (phase == 3'h3 && byte_ok) begin
              req_wr   <= 1'b1;
              req_cmd  <= cmd;
              req_data <= {shreg, low_byte};
              req_tgl  <= ~req_tgl;
            end
            SDA_OE <= byte_ok;
            st     <= byte_ok ? ftcr_pkg::LINK_ACK : ftcr_pkg::LINK_IDLE;
          end
        end
        ftcr_pkg::LINK_ACK: begin
          if (scl_fall) begin
            if (rd_mode) begin
              shreg  <= first_tx;
              SDA_OE <= ~first_tx[7];
              txi    <= 5'h01;
              bitcnt <= 4'h0;
              st     <= ftcr_pkg::LINK_TX;
            end else begin
              SDA_OE <= 1'b0;
              st     <= ftcr_pkg::LINK_RX;
            end
          end
        end
        ftcr_pkg::LINK_TX: begin
          if (scl_fall) begin
            if (bitcnt == 4'h7) begin
              bitcnt <= 4'h0;
              SDA_OE <= 1'b0;
              st     <= ftcr_pkg::LINK_MACK;
            end else begin
              bitcnt <= bitcnt + 4'h1;
              shreg  <= {shreg[6:0], 1'b0};
              SDA_OE <= ~shreg[6];
            end
          end
        end
        ftcr_pkg::LINK_MACK: begin
          if (scl_rise) begin
            nack <= sda_q[1];
          end else if (scl_fall) begin
            if (nack) begin
              st <= ftcr_pkg::LINK_IDLE;
            end else begin
              shreg  <= next_tx;
              SDA_OE <= ~next_tx[7];
              if (txi != 5'h1F) begin
                txi <= txi + 5'h01;
              end
              st <= ftcr_pkg::LINK_TX;
            end
          end
        end
        default: begin
          st <= ftcr_pkg::LINK_IDLE;
        end
      endcase
    end
  end

  // Read word taken from the core once its answer toggle has crossed
  always_ff @(posedge LINK_CLK) begin
    ack_q <= {ack_q[1:0], ack_tgl};
    if (lrst) begin
      rd_word <= 16'h0000;
    end else if (ack_q[1] ^ ack_q[2]) begin
      rd_word <= core_rdata;
    end
  end

  // --------------------------------------------------------------------------
  // Core domain: request crossing and word storage
  // --------------------------------------------------------------------------
  logic [2:0]           req_q;
  logic                 req_go;
  ftcr_pkg::ftcr_word_t cfg [`FTCR_WORD_COUNT];

  always_ff @(posedge CORE_CLK) begin
    req_q <= {req_q[1:0], req_tgl};
  end

  assign req_go = req_q[1] ^ req_q[2];

  // Word write and read answer
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      ack_tgl    <= 1'b0;
      core_rdata <= 16'h0000;
      for (int i = 0; i < `FTCR_WORD_COUNT; i++) begin
        cfg[i] <= `FTCR_WORD_RESET;
      end
    end else if (req_go) begin
      ack_tgl <= ~ack_tgl;
      if (is_word_cmd(req_cmd)) begin
        core_rdata <= cfg[word_index(req_cmd)];
        if (req_wr) begin
          cfg[word_index(req_cmd)] <= req_data;
        end
      end else begin
        core_rdata <= `FTCR_READ_UNMAPPED;
      end
    end
  end

  ftcr_pkg::ftcr_word_t dly;
  ftcr_pkg::ftcr_word_t hu_thr;
  ftcr_pkg::ftcr_word_t dis_thr;
  ftcr_pkg::ftcr_word_t en_thr;
  ftcr_pkg::ftcr_word_t raise_thr;
  ftcr_pkg::ftcr_word_t cease_thr;

  assign dly       = cfg[word_index(`FTCR_CMD_OUT2_DELAY)];
  assign hu_thr    = cfg[word_index(`FTCR_CMD_HOLDUP_TRIG)];
  assign dis_thr   = cfg[word_index(`FTCR_CMD_DISABLE_THR)];
  assign en_thr    = cfg[word_index(`FTCR_CMD_ENABLE_THR)];
  assign raise_thr = cfg[word_index(`FTCR_CMD_RAISE_THR)];
  assign cease_thr = cfg[word_index(`FTCR_CMD_CEASE_THR)];

  // Calibration words straight from storage
  assign CAL_FA_POS   = cfg[word_index(`FTCR_CMD_FA_POS_CAL)];
  assign CAL_FA_NEG   = cfg[word_index(`FTCR_CMD_FA_NEG_CAL)];
  assign CAL_FA_OFS   = cfg[word_index(`FTCR_CMD_FA_OFS_CAL)];
  assign CAL_FB_POS   = cfg[word_index(`FTCR_CMD_FB_POS_CAL)];
  assign CAL_FB_NEG   = cfg[word_index(`FTCR_CMD_FB_NEG_CAL)];
  assign CAL_FB_OFS   = cfg[word_index(`FTCR_CMD_FB_OFS_CAL)];
  assign CAL_I1_SLOPE = cfg[word_index(`FTCR_CMD_I1_SLOPE_CAL)];
  assign CAL_I1_OFS   = cfg[word_index(`FTCR_CMD_I1_OFS_CAL)];

  // --------------------------------------------------------------------------
  // Core domain: threshold decisions, all words in one direct format
  // --------------------------------------------------------------------------
  logic [1:0] ena_q;
  logic [1:0] enb_q;
  logic       both_low;
  logic       any_high;
  logic       any_raise;
  logic       both_cease;
  logic       holdup_lvl;

  // Enable pins pass two flops
  always_ff @(posedge CORE_CLK) begin
    ena_q <= {ena_q[0], EN_A_PLUGGED};
    enb_q <= {enb_q[0], EN_B_PLUGGED};
  end

  assign both_low   = (VIN_A < dis_thr) && (VIN_B < dis_thr);
  assign any_high   = (VIN_A > en_thr) || (VIN_B > en_thr);
  assign any_raise  = (VIN_A < raise_thr) || (VIN_B < raise_thr);
  assign both_cease = (VIN_A > cease_thr) && (VIN_B > cease_thr);
  assign holdup_lvl = (VOUT <= hu_thr) && (VIN_A <= hu_thr) && (VIN_B <= hu_thr);

  // Output on/off with hysteresis
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      OUTPUTS_ON <= 1'b0;
    end else if (both_low) begin
      OUTPUTS_ON <= 1'b0;
    end else if (any_high) begin
      OUTPUTS_ON <= 1'b1;
    end
  end

  // Per-feed enable status
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      FEED_A_EN <= 1'b0;
      FEED_B_EN <= 1'b0;
    end else begin
      if (VIN_A < dis_thr || !ena_q[1]) begin
        FEED_A_EN <= 1'b0;
      end else if (VIN_A > en_thr) begin
        FEED_A_EN <= 1'b1;
      end
      if (VIN_B < dis_thr || !enb_q[1]) begin
        FEED_B_EN <= 1'b0;
      end else if (VIN_B > en_thr) begin
        FEED_B_EN <= 1'b1;
      end
    end
  end

  // Feed alarm, output voltage good, hold-up
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      FEED_ALARM  <= 1'b0;
      OUT_VOLT_OK <= 1'b0;
      HOLDUP_ON   <= 1'b0;
    end else begin
      if (any_raise) begin
        FEED_ALARM <= 1'b1;
      end else if (both_cease) begin
        FEED_ALARM <= 1'b0;
      end
      if (VOUT < hu_thr) begin
        OUT_VOLT_OK <= 1'b0;
      end else if (VOUT > hu_thr) begin
        OUT_VOLT_OK <= 1'b1;
      end
      HOLDUP_ON <= holdup_lvl;
    end
  end

  // --------------------------------------------------------------------------
  // Core domain: output 2 start delay in milliseconds
  // --------------------------------------------------------------------------
  logic [15:0] pre_cnt;
  logic [15:0] ms_cnt;

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST || !OUTPUTS_ON) begin
      pre_cnt    <= 16'h0000;
      ms_cnt     <= 16'h0000;
      OUT2_START <= 1'b0;
    end else if (!OUT2_START) begin
      if (ms_cnt >= dly) begin
        OUT2_START <= 1'b1;
      end else if (pre_cnt == 16'(CYC_PER_MS - 1)) begin
        pre_cnt <= 16'h0000;
        ms_cnt  <= ms_cnt + 16'h0001;
      end else begin
        pre_cnt <= pre_cnt + 16'h0001;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  off_both_low_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    both_low |=> !OUTPUTS_ON) else $error("outputs stayed on with both feeds low");
  on_either_high_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (any_high && !both_low) |=> OUTPUTS_ON) else $error("outputs not on with a feed high");
  hyst_hold_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (!any_high && !both_low) |=> $stable(OUTPUTS_ON)) else $error("outputs moved in band");
  alarm_raise_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    any_raise |=> FEED_ALARM) else $error("feed alarm not raised");
  alarm_cease_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (!any_raise && both_cease) |=> !FEED_ALARM) else $error("feed alarm not ceased");
  feed_a_clear_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (VIN_A < dis_thr || !ena_q[1]) |=> !FEED_A_EN) else $error("feed A enable not cleared");
  feed_b_set_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (VIN_B > en_thr && VIN_B >= dis_thr && enb_q[1]) |=> FEED_B_EN)
    else $error("feed B enable not set");
  volt_ok_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (VOUT != hu_thr) |=> (OUT_VOLT_OK == $past(VOUT > hu_thr)))
    else $error("output voltage bit wrong");
  holdup_lvl_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    holdup_lvl[*2] |-> HOLDUP_ON) else $error("hold-up not engaged");
  out2_wait_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    $rose(OUT2_START) |-> ($past(OUTPUTS_ON) && $past(ms_cnt) >= $past(dly)))
    else $error("output 2 started early");
  out2_off_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    !OUTPUTS_ON |=> !OUT2_START) else $error("output 2 on with outputs off");
  word_write_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (req_go && req_wr && req_cmd == `FTCR_CMD_RAISE_THR) |=> raise_thr == $past(req_data))
    else $error("word write lost");
  fw_no_write_a: assert property (@(posedge LINK_CLK) disable iff (lrst)
    (st == ftcr_pkg::LINK_RX && scl_fall && bitcnt == 4'h8 && phase == 3'h2
     && cmd == `FTCR_CMD_FW_INFO && !bus_start && !bus_stop)
    |=> (st == ftcr_pkg::LINK_IDLE && !SDA_OE)) else $error("firmware write acknowledged");

  outputs_on_c: cover property (@(posedge CORE_CLK) disable iff (SYS_RST) $rose(OUTPUTS_ON));
  out2_start_c: cover property (@(posedge CORE_CLK) disable iff (SYS_RST) $rose(OUT2_START));
  word_write_c: cover property (@(posedge CORE_CLK) disable iff (SYS_RST) req_go && req_wr);
  fw_read_c: cover property (@(posedge LINK_CLK) disable iff (lrst)
    st == ftcr_pkg::LINK_TX && cmd == `FTCR_CMD_FW_INFO && txi == 5'h14);

endmodule

//--- test/ftcr_host.sv
// Management bus host model: push-pull clock and open-drain data master
`timescale 1ns/1ps
module ftcr_host (
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  // Bus idles with data released and pulled high, clock driven high
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // One bit: data set while clock low, sampled in the high phase
  task automatic bit_io(input logic b, output logic r);
    #250 sda_low = !b;
    #500 scl = 1'b1;
    #250 r = sda;
    #250 scl = 1'b0;
  endtask
  // Start or repeated start: data falls while clock is high
  task automatic start();
    #500 sda_low = 1'b0;
    #500 scl = 1'b1;
    #1000 sda_low = 1'b1;
    #1000 scl = 1'b0;
  endtask
  // Stop: data rises while clock high, clock then stands still
  task automatic stop();
    #250 sda_low = 1'b1;
    #500 scl = 1'b1;
    #1000 sda_low = 1'b0;
    #1000;
  endtask
  // Byte out, top bit first; ack is data low in the ninth bit
  task automatic tx(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  // Byte in; host acks all but the last byte
  task automatic rx(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask
endmodule

//--- test/tb_ftcr_regs.sv
// Self-checking bench for the feed threshold register block
`timescale 1ns/1ps
`include "ftcr_defines.svh"
module tb_ftcr_regs;
  logic        core_clk = 1'b0;
  logic        link_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        plug_a = 1'b1;
  logic        plug_b = 1'b1;
  logic [15:0] vin_a = 16'h0000;
  logic [15:0] vin_b = 16'h0000;
  logic [15:0] vout = 16'h0000;
  logic        scl, sda_low, sda, sda_out, sda_oe;
  logic        on, out2, holdup, en_a, en_b, alarm, vok;
  logic [15:0] cal [8];
  logic [3:0]  acks;
  logic [7:0]  rb [21];
  logic [159:0] fs = `FTCR_FW_STRING;
  logic [7:0]  rc [4] = '{8'hE3, 8'hE7, 8'hE8, 8'hEC};
  logic [15:0] wv [15] = '{16'h0002, 16'hBEEF, 16'h0800, 16'h0A00, 16'h0C00,
    16'h0B00, 16'h0D00, 16'hF001, 16'h8002, 16'h7FF3, 16'hFFF4, 16'h0005,
    16'hA006, 16'h1237, 16'h8008};
  int          mismatches = 0;
  int          samples_checked = 0;
  int          cyc = 0;

  // Clocks, the link one unrelated in phase
  always #10 core_clk = ~core_clk;
  initial #7 forever #62.5 link_clk = ~link_clk;
  // Open-drain data wire with pull-up
  assign sda = (sda_oe ? sda_out : 1'b1) & !sda_low;

  ftcr_host hst (.scl(scl), .sda_low(sda_low), .sda(sda));
  ftcr_regs #(.CYC_PER_MS(4)) dut_u (
    .CORE_CLK(core_clk), .SYS_RST(sys_rst), .LINK_CLK(link_clk),
    .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
    .EN_A_PLUGGED(plug_a), .EN_B_PLUGGED(plug_b),
    .VIN_A(vin_a), .VIN_B(vin_b), .VOUT(vout),
    .OUTPUTS_ON(on), .OUT2_START(out2), .HOLDUP_ON(holdup),
    .FEED_A_EN(en_a), .FEED_B_EN(en_b), .FEED_ALARM(alarm), .OUT_VOLT_OK(vok),
    .CAL_FA_POS(cal[0]), .CAL_FA_OFS(cal[1]), .CAL_I1_SLOPE(cal[2]),
    .CAL_I1_OFS(cal[3]), .CAL_FA_NEG(cal[4]), .CAL_FB_POS(cal[5]),
    .CAL_FB_OFS(cal[6]), .CAL_FB_NEG(cal[7])
  );

  // Value compare
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // Status flags {on, out2, holdup, en_a, en_b, alarm, vok}
  task automatic st(input logic [6:0] e);
    chk("status flags", 16'(e), 16'({on, out2, holdup, en_a, en_b, alarm, vok}));
  endtask
  // Word write, low byte first
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    hst.start();
    hst.tx({`FTCR_SLAVE_ADDR, 1'b0}, acks[3]);
    hst.tx(c, acks[2]);
    hst.tx(d[7:0], acks[1]);
    hst.tx(d[15:8], acks[0]);
    hst.stop();
  endtask
  // Read of n bytes after a repeated start
  task automatic rd(input logic [7:0] c, input int n);
    hst.start();
    hst.tx({`FTCR_SLAVE_ADDR, 1'b0}, acks[3]);
    hst.tx(c, acks[2]);
    #10000;
    hst.start();
    hst.tx({`FTCR_SLAVE_ADDR, 1'b1}, acks[1]);
    for (int i = 0; i < n; i++) hst.rx(i == n - 1, rb[i]);
    hst.stop();
  endtask
  // Feed and output levels at the falling edge, then settle
  task automatic put(input logic [15:0] a, input logic [15:0] b, input logic [15:0] o);
    @(negedge core_clk);
    vin_a = a;
    vin_b = b;
    vout = o;
    repeat (6) @(negedge core_clk);
  endtask
  // Verdict and end of run
  task automatic finish_test();
    $display("Checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 90000) begin
      mismatches++;
      finish_test();
    end
  end

  // Main sequence
  initial begin
    repeat (32) @(negedge core_clk);
    sys_rst = 1'b0;
    repeat (40) @(negedge core_clk);
    rd(8'hE6, 2);
    chk("reset word", 16'h0000, {rb[1], rb[0]});
    for (int i = 0; i < 15; i++) begin
      wr(8'hE2 + 8'(i), wv[i]);
      chk("write acks", 16'h000F, 16'(acks));
    end
    repeat (10) @(negedge core_clk);
    for (int i = 0; i < 8; i++) chk("cal port", wv[7 + i], cal[i]);
    foreach (rc[i]) begin
      rd(rc[i], 2);
      chk("read word", wv[rc[i] - 8'hE2], {rb[1], rb[0]});
    end
    rd(8'hFD, 21);
    chk("fw length", 16'h0014, 16'(rb[0]));
    for (int i = 0; i < 20; i++) chk("fw byte", 16'(fs[159 - 8 * i -: 8]), 16'(rb[i + 1]));
    wr(8'hFD, 16'h0000);
    chk("fw write acks", 16'h000C, 16'(acks));
    put(16'h0000, 16'h0000, 16'h0000);
    st(7'b0010010);
    put(16'h0C01, 16'h0000, 16'h0000);
    st(7'b1001010);
    repeat (12) @(negedge core_clk);
    st(7'b1101010);
    put(16'h0B80, 16'h0000, 16'h0000);
    st(7'b1101010);
    put(16'h0D01, 16'h0D01, 16'h0900);
    st(7'b1101101);
    plug_a = 1'b0;
    put(16'h0D01, 16'h0D01, 16'h0900);
    st(7'b1100101);
    put(16'h09FF, 16'h09FF, 16'h0900);
    st(7'b0000011);
    finish_test();
  end
endmodule
